// *** rtl/ccp_pkg.sv ***
// Package of constants and types for the configuration control-pin block
package ccp_pkg;
  // ****************************************************************
  // Register map, byte addresses on the Avalon-MM slave
  // ****************************************************************
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] RBDATA_ADDR = 4'h8;
  localparam logic [3:0] CFGDATA_ADDR = 4'hc;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RBDATA_RESET = 32'h0000_0000;

  // ****************************************************************
  // Link roles chosen by software in the control register role field
  // ****************************************************************
  localparam logic [1:0] ROLE_SLAVE = 2'h0;
  localparam logic [1:0] ROLE_MASTER = 2'h1;
  localparam logic [1:0] ROLE_PERIPH = 2'h2;
  localparam logic [1:0] ROLE_MPAR = 2'h3;

  // Control register layout, high bit first
  typedef struct packed {
    logic [22:0] unused;
    logic bscan_sel;      // Bit 8: boundary scan kept after configuration
    logic rb_global_tristate;      // Bit 7: trigger keeps its tristate-all role
    logic [1:0] role;     // Bits 6:5
    logic init_fail;      // Bit 4: memory or core initialisation failed
    logic done_pullup;    // Bit 3
    logic rb_enable;      // Bit 2: readback option
    logic load_done;      // Bit 1: configuration data fully loaded
    logic rsvd0;          // Bit 0
  } ccp_ctrl_t;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_CLEAR = 5'h01,
    ST_WAIT = 5'h02,
    ST_LOAD = 5'h04,
    ST_HOLD = 5'h08,
    ST_RUN = 5'h10
  } ccp_state_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ = 10000;
  localparam int CLEAR_TIME_NS = 2000;  // Memory clearing time
  localparam int BUSY_TIME_NS = 1000;   // Byte absorption time
  localparam int CLEAR_CYC = (CLEAR_TIME_NS * CLK_KHZ + 999999) / 1000000;
  localparam int BUSY_CYC = (BUSY_TIME_NS * CLK_KHZ + 999999) / 1000000;
  localparam int STROBE_HALF = 4;       // Own strobe half period in cycles
  localparam int SYNC_W = 22;
  localparam int RB_WORD = 32;
endpackage

// *** rtl/ccp_top.sv ***
// Configuration control-pin logic: strobe clock, done, restart, readback, mode latch
`timescale 1ns/10ps

// Summary of operation
// - Master and peripheral modes drive strobe clock
// - Slave and readback sample external strobe clock
// - Chain lead drives strobe clock downstream
// - Low done input holds off start-up
// - Done released high when complete; optional pull-up
// - Restart input restarts configuration, resets scan
// - Low trigger during configuration tristates I/O
// - Trigger falling edge starts readback at frame 0
// - Readback data shares pin with scan output
// - Error output low on init failure during load, then interrupt
// - Mode inputs captured on init rising edge
// - Scan disabled after configuration unless selected
// - Byte-ready output, mirrored on status bit line
// - Master parallel drives memory read strobe
// - Read strobe makes status bit; write overrides
// - Init held low while clearing; low input waits
module ccp_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic config_strobe_clock_i,
  output logic config_strobe_clock_o,
  output logic config_strobe_clock_oe_o,
  input wire logic serial_data_i,
  input wire logic [7:0] byte_data_i,
  input wire logic done_i,
  output logic done_o,
  output logic done_oe_o,
  output logic done_pullup_o,
  input wire logic program_restart_n_i,
  input wire logic readback_trigger_n_i,
  output logic readback_data_o,
  input wire logic scan_tdo_i,
  output logic scan_enable_o,
  output logic scan_reset_o,
  output logic global_tristate_o,
  output logic error_n_o,
  output logic error_n_oe_o,
  input wire logic host_port_interrupt_n_i,
  input wire logic [3:0] mode_select_i,
  output logic [3:0] mode_latched_o,
  input wire logic init_i,
  output logic init_o,
  output logic init_oe_o,
  input wire logic select_low_input_i,
  input wire logic select_high_input_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  output logic byte_ready_o,
  output logic status_bit_line_o,
  output logic status_bit_line_oe_o,
  output logic mem_read_strobe_o,
  output logic startup_o
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [ccp_pkg::SYNC_W-1:0] raw_in;
  logic [ccp_pkg::SYNC_W-1:0] s1_r;
  logic [ccp_pkg::SYNC_W-1:0] s2_r;
  logic [ccp_pkg::SYNC_W-1:0] s3_r;

  // Every pin-side input except host_port_interrupt_n_i and scan_tdo_i is taken through two flops before use
  assign raw_in = {config_strobe_clock_i, done_i, program_restart_n_i, readback_trigger_n_i,
                   init_i, select_low_input_i, select_high_input_i, read_strobe_n_i,
                   write_strobe_n_i, serial_data_i, mode_select_i, byte_data_i};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Named synchronised levels; s3 only serves edge detection
  wire ext_clk = s2_r[21];
  wire done_s = s2_r[20];
  wire restart_n_s = s2_r[19];
  wire trig_n_s = s2_r[18];
  wire init_s = s2_r[17];
  wire sel_lo_s = s2_r[16];
  wire sel_hi_s = s2_r[15];
  wire rd_n_s = s2_r[14];
  wire wr_n_s = s2_r[13];
  wire din_s = s2_r[12];
  wire [3:0] mode_s = s2_r[11:8];
  wire [7:0] byte_s = s2_r[7:0];
  wire ext_rise = ext_clk & ~s3_r[21];
  wire ext_fall = ~ext_clk & s3_r[21];
  wire init_rise = init_s & ~s3_r[17];
  wire trig_fall = ~trig_n_s & s3_r[18];
  wire wr_fall = ~wr_n_s & s3_r[13];

  // ****************************************************************
  // Registers and sequencer state
  // ****************************************************************
  ccp_pkg::ccp_ctrl_t ctrl_r;
  ccp_pkg::ccp_state_t state_r;
  ccp_pkg::ccp_state_t state_nxt;
  logic [31:0] rbdata_r;
  logic [31:0] rb_shift_r;
  logic [4:0] rb_bit_r;
  logic [15:0] rb_frame_r;
  logic rb_active_r;
  logic [7:0] cfg_shift_r;
  logic [7:0] cfg_byte_r;
  logic [2:0] cfg_bit_r;
  logic [15:0] clear_cnt_r;
  logic [15:0] busy_cnt_r;
  logic [7:0] div_cnt_r;
  logic own_clk_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [3:0] mode_r;

  wire in_cfg = (state_r != ccp_pkg::ST_RUN);
  wire in_load = (state_r == ccp_pkg::ST_LOAD);
  wire own_role = (ctrl_r.role != ccp_pkg::ROLE_SLAVE);
  wire selected = ~sel_lo_s & sel_hi_s;
  wire own_rise = (div_cnt_r == 8'(ccp_pkg::STROBE_HALF - 1)) & ~own_clk_r;
  wire data_edge = own_role ? own_rise : ext_rise;
  wire byte_take = in_load & (ctrl_r.role == ccp_pkg::ROLE_PERIPH) & selected & wr_fall;
  wire rdy = (busy_cnt_r == 16'h0000);

  // ****************************************************************
  // Avalon-MM slave: one wait cycle, then the answer cycle
  // ****************************************************************
  wire req = avs_read_i | avs_write_i;
  wire wr_take = avs_write_i & ~wait_r;
  wire hit_ctrl = (avs_address_i == ccp_pkg::CTRL_ADDR);
  wire hit_stat = (avs_address_i == ccp_pkg::STATUS_ADDR);
  wire hit_rb = (avs_address_i == ccp_pkg::RBDATA_ADDR);
  wire hit_cfg = (avs_address_i == ccp_pkg::CFGDATA_ADDR);
  wire [31:0] status_w = {4'h0, rb_frame_r, rb_active_r, done_s, mode_r, 1'b0, state_r};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_stat ? status_w :
                       hit_rb ? rbdata_r :
                       hit_cfg ? {24'h000000, cfg_byte_r} : 32'h0000_0000;

  // Unmapped reads answer zero, unmapped writes are dropped
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~(req & wait_r);
      if (req & wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= ccp_pkg::CTRL_RESET;
      rbdata_r <= ccp_pkg::RBDATA_RESET;
    end else if (!restart_n_s) begin
      ctrl_r.load_done <= 1'b0;                              // Restart forgets the load
    end else if (wr_take & hit_ctrl) begin
      ctrl_r <= avs_writedata_i;
    end else if (wr_take & hit_rb) begin
      rbdata_r <= avs_writedata_i;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ccp_pkg::ST_CLEAR: begin
        if (clear_cnt_r == 16'(ccp_pkg::CLEAR_CYC - 1)) begin
          state_nxt = ccp_pkg::ST_WAIT;
        end
      end
      ccp_pkg::ST_WAIT: begin
        if (init_rise) begin
          state_nxt = ccp_pkg::ST_LOAD;
        end
      end
      ccp_pkg::ST_LOAD: begin
        if (ctrl_r.load_done) begin
          state_nxt = ccp_pkg::ST_HOLD;
        end
      end
      ccp_pkg::ST_HOLD: begin
        if (done_s) begin
          state_nxt = ccp_pkg::ST_RUN;
        end
      end
      ccp_pkg::ST_RUN: state_nxt = ccp_pkg::ST_RUN;
      default: state_nxt = ccp_pkg::ST_CLEAR;
    endcase
    if (!restart_n_s) begin
      state_nxt = ccp_pkg::ST_CLEAR;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ccp_pkg::ST_CLEAR;
      clear_cnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      // Clearing time restarts from zero while restart is still held
      clear_cnt_r <= ((state_r == ccp_pkg::ST_CLEAR) & restart_n_s) ? clear_cnt_r + 16'h0001
                                                                    : 16'h0000;
    end
  end

  // Mode value is kept opaque; software maps it to a role
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_r <= 4'h0;
    end else if ((state_r == ccp_pkg::ST_WAIT) & init_rise) begin
      mode_r <= mode_s;
    end
  end

  // ****************************************************************
  // Own strobe clock divider and data capture
  // ****************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt_r <= 8'h00;
      own_clk_r <= 1'b0;
    end else if (div_cnt_r == 8'(ccp_pkg::STROBE_HALF - 1)) begin
      div_cnt_r <= 8'h00;
      own_clk_r <= ~own_clk_r;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  // Serial bits on strobe edges, or whole bytes on peripheral writes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_shift_r <= 8'h00;
      cfg_bit_r <= 3'h0;
      cfg_byte_r <= 8'h00;
      busy_cnt_r <= 16'h0000;
    end else if (!in_load) begin
      cfg_bit_r <= 3'h0;
      busy_cnt_r <= 16'h0000;
    end else if (byte_take & rdy) begin
      cfg_byte_r <= byte_s;
      busy_cnt_r <= 16'(ccp_pkg::BUSY_CYC);
    end else begin
      if (busy_cnt_r != 16'h0000) begin
        busy_cnt_r <= busy_cnt_r - 16'h0001;
      end
      if (data_edge & (ctrl_r.role != ccp_pkg::ROLE_PERIPH)) begin
        cfg_shift_r <= {cfg_shift_r[6:0], din_s};
        cfg_bit_r <= cfg_bit_r + 3'h1;
        if (cfg_bit_r == 3'h7) begin
          cfg_byte_r <= {cfg_shift_r[6:0], din_s};
        end
      end
    end
  end

  // ****************************************************************
  // Readback on the external strobe clock after configuration
  // ****************************************************************
  // Trigger edges before the run state are ignored; there a low trigger tristates I/O instead
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rb_active_r <= 1'b0;
      rb_shift_r <= 32'h0000_0000;
      rb_bit_r <= 5'h00;
      rb_frame_r <= 16'h0000;
    end else if (state_r != ccp_pkg::ST_RUN) begin
      rb_active_r <= 1'b0;
    end else if (trig_fall & ctrl_r.rb_enable & ~ctrl_r.rb_global_tristate) begin
      rb_active_r <= 1'b1;
      rb_frame_r <= 16'h0000;
      rb_shift_r <= rbdata_r;
      rb_bit_r <= 5'h00;
    end else if (rb_active_r & ext_fall) begin
      rb_shift_r <= {rb_shift_r[30:0], 1'b0};
      rb_bit_r <= rb_bit_r + 5'h01;
      if (rb_bit_r == 5'(ccp_pkg::RB_WORD - 1)) begin
        rb_shift_r <= rbdata_r;                              // Next frame from software
        rb_frame_r <= rb_frame_r + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Pin drivers, all registered
  // ****************************************************************
  wire scan_on = in_cfg | ctrl_r.bscan_sel;
  wire ts_cfg = in_cfg & ~trig_n_s;
  wire ts_run = ~in_cfg & ctrl_r.rb_global_tristate & ~trig_n_s;
  wire rd_status = in_load & (ctrl_r.role == ccp_pkg::ROLE_PERIPH) & selected
                   & ~rd_n_s & wr_n_s;
  wire err_drive = in_cfg ? (in_load & ctrl_r.init_fail)
                          : ~host_port_interrupt_n_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      config_strobe_clock_o <= 1'b0;
      config_strobe_clock_oe_o <= 1'b0;
      done_oe_o <= 1'b1;
      done_pullup_o <= 1'b0;
      init_oe_o <= 1'b1;
      readback_data_o <= 1'b0;
      scan_enable_o <= 1'b1;
      scan_reset_o <= 1'b1;
      global_tristate_o <= 1'b1;
      error_n_oe_o <= 1'b0;
      byte_ready_o <= 1'b0;
      status_bit_line_o <= 1'b0;
      status_bit_line_oe_o <= 1'b0;
      mem_read_strobe_o <= 1'b0;
      startup_o <= 1'b0;
      mode_latched_o <= 4'h0;
    end else begin
      config_strobe_clock_o <= own_clk_r;
      config_strobe_clock_oe_o <= in_load & own_role;
      done_oe_o <= in_cfg & (state_r != ccp_pkg::ST_HOLD);
      done_pullup_o <= ctrl_r.done_pullup;
      init_oe_o <= (state_r == ccp_pkg::ST_CLEAR);
      readback_data_o <= ctrl_r.bscan_sel & ~rb_active_r ? scan_tdo_i
                                                         : rb_shift_r[31];
      scan_enable_o <= scan_on;
      scan_reset_o <= ~restart_n_s;
      global_tristate_o <= ts_cfg | ts_run;
      error_n_oe_o <= err_drive;
      byte_ready_o <= in_load & (ctrl_r.role == ccp_pkg::ROLE_PERIPH) & rdy;
      status_bit_line_o <= rdy;
      status_bit_line_oe_o <= rd_status;
      mem_read_strobe_o <= in_load & (ctrl_r.role == ccp_pkg::ROLE_MPAR)
                           & ~own_clk_r;
      startup_o <= ~in_cfg;
      mode_latched_o <= mode_r;
    end
  end

  // Open-drain pins only ever pull low
  assign done_o = 1'b0;
  assign init_o = 1'b0;
  assign error_n_o = 1'b0;
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
endmodule

// *** tb/ccp_checker.sv ***
// Port-level assertions for the configuration control-pin block
`timescale 1ns/10ps
module ccp_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic done_i,
  input wire logic done_oe_o,
  input wire logic program_restart_n_i,
  input wire logic readback_trigger_n_i,
  input wire logic host_port_interrupt_n_i,
  input wire logic init_i,
  input wire logic init_oe_o,
  input wire logic [3:0] mode_latched_o,
  input wire logic startup_o,
  input wire logic scan_reset_o,
  input wire logic global_tristate_o,
  input wire logic error_n_oe_o,
  input wire logic write_strobe_n_i,
  input wire logic byte_ready_o,
  input wire logic status_bit_line_o,
  input wire logic status_bit_line_oe_o,
  input wire logic config_strobe_clock_o,
  input wire logic config_strobe_clock_oe_o,
  input wire logic mem_read_strobe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ****************************************************************
  // Stimulus sequences
  // ****************************************************************
  // Long enough to pass the pin synchronisers and the state update
  sequence restart_held;
    !program_restart_n_i [*6];
  endsequence
  sequence trig_low_cfg;
    (!readback_trigger_n_i && !startup_o) [*5];
  endsequence
  // ****************************************************************
  // Checks
  // ****************************************************************
  // Pins and strobes tied to their causes
  done_rel_a: assert property (startup_o |-> !done_oe_o)
    else $error("done still driven after start-up");
  hold_off_a: assert property ((!done_i) [*4] |=> !$rose(startup_o))
    else $error("start-up while done held low");
  restart_a: assert property (restart_held |-> scan_reset_o && init_oe_o && !startup_o)
    else $error("restart not honoured");
  tristate_a: assert property (trig_low_cfg |-> global_tristate_o)
    else $error("trigger low left outputs active");
  strobe_half_a: assert property ($rose(config_strobe_clock_o) |=>
    (config_strobe_clock_o || !config_strobe_clock_oe_o) [*3])
    else $error("own strobe high phase too short");
  mem_strobe_a: assert property (mem_read_strobe_o |-> config_strobe_clock_oe_o)
    else $error("memory strobe outside own strobe mode");
  irq_out_a: assert property (error_n_oe_o && startup_o |->
    $past(host_port_interrupt_n_i) == 1'b0)
    else $error("interrupt output without request");
  mode_hold_a: assert property ($changed(mode_latched_o) |-> $past(init_i))
    else $error("mode changed without init high");
  mirror_a: assert property (status_bit_line_oe_o |-> status_bit_line_o == byte_ready_o)
    else $error("status line differs from byte ready");
  wr_over_a: assert property ((!write_strobe_n_i) [*4] |-> !status_bit_line_oe_o)
    else $error("status driven during write");
endmodule

bind ccp_top ccp_checker u_chk (.*);

// *** tb/ccp_src_model.sv ***
// Configuration source model: external strobe, serial bits and peripheral bytes
`timescale 1ns/10ps
module ccp_src_model (
  input wire logic clk_i,
  output logic strobe_o,
  output logic serial_o,
  output logic [7:0] byte_o,
  output logic sel_low_o,
  output logic sel_high_o,
  output logic rd_n_o,
  output logic wr_n_o
);
  // Idle: strobe parked low, deselected, pulled-up pins high
  // Mode select sits outside this block and is driven by the bench
  initial begin
    strobe_o = 1'b0;
    serial_o = 1'b0;
    byte_o = 8'h00;
    sel_low_o = 1'b1;
    sel_high_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
  end
  // Slave frame at 800 ns, odd phase offset so it never lines up with the clock
  task automatic frame(input int n, input logic [7:0] b);
    #37;
    for (int i = 7; i > 7 - n; i--) begin
      serial_o = b[i];
      #400 strobe_o = 1'b1;
      #400 strobe_o = 1'b0;
    end
    serial_o = ~serial_o;
  endtask
  // Selected byte write; bus shows the inverse once released
  task automatic put_byte(input logic [7:0] b);
    @(posedge clk_i);
    sel_low_o <= 1'b0;
    byte_o <= b;
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
    sel_low_o <= 1'b1;
    byte_o <= ~b;
  endtask
  // Selected status read on or off
  task automatic poll(input logic on);
    @(posedge clk_i);
    sel_low_o <= !on;
    rd_n_o <= !on;
  endtask
endmodule

// *** tb/ccp_top_tb.sv ***
// Self-checking bench for the configuration control-pin block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module ccp_top_tb;
  logic clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, scan_tdo_i;
  logic [3:0] avs_address_i, mode_select_i, mode_latched_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd, w;
  logic [7:0] byte_data_i;
  logic config_strobe_clock_i, config_strobe_clock_o, config_strobe_clock_oe_o, serial_data_i;
  logic done_i, done_o, done_oe_o, done_pullup_o, program_restart_n_i, readback_trigger_n_i;
  logic readback_data_o, scan_enable_o, scan_reset_o, global_tristate_o, error_n_o;
  logic error_n_oe_o, host_port_interrupt_n_i, init_i, init_o, init_oe_o;
  logic select_low_input_i, select_high_input_i, read_strobe_n_i, write_strobe_n_i;
  logic byte_ready_o, status_bit_line_o, status_bit_line_oe_o, mem_read_strobe_o, startup_o;
  logic m_strobe, hold_init, hold_done, p;
  int fails = 0;
  int n_tests = 0;
  int k;

  ccp_top u_dut (.*);
  ccp_src_model u_src (.clk_i(clk_i), .strobe_o(m_strobe), .serial_o(serial_data_i),
    .byte_o(byte_data_i), .sel_low_o(select_low_input_i), .sel_high_o(select_high_input_i),
    .rd_n_o(read_strobe_n_i), .wr_n_o(write_strobe_n_i));
  // Shared pins: open-drain with pull-ups, strobe driven by whoever owns it
  assign config_strobe_clock_i = config_strobe_clock_oe_o ? config_strobe_clock_o : m_strobe;
  assign done_i = !(done_oe_o || hold_done);
  assign init_i = !(init_oe_o || hold_init);

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Waits whole cycles, then lets the edge's updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50) fails++;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short; the full run takes under a tenth of this
  initial begin
    #500000;
    fails++;
    $display("watchdog expired");
    end_sim;
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    reset_n_i = 1'b0;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    scan_tdo_i = 1'b0;
    program_restart_n_i = 1'b1;
    readback_trigger_n_i = 1'b1;
    host_port_interrupt_n_i = 1'b1;
    mode_select_i = 4'ha;
    hold_init = 1'b1;
    hold_done = 1'b1;
    cyc(2);
    `CHK("init_oe reset", 1'b1, init_oe_o)
    reset_n_i = 1'b1;
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b0, ccp_pkg::CTRL_ADDR, 32'h0);
    `CHK("ctrl reset", ccp_pkg::CTRL_RESET, rd)
    cyc(30);
    bus(1'b0, ccp_pkg::STATUS_ADDR, 32'h0);
    `CHK("state wait", 5'h02, rd[4:0])
    mode_select_i = 4'h5;
    cyc(4);
    hold_init = 1'b0;
    cyc(8);
    mode_select_i = 4'h3;
    cyc(6);
    `CHK("mode pins", 4'h5, mode_latched_o)
    bus(1'b0, ccp_pkg::STATUS_ADDR, 32'h0);
    `CHK("state load", 5'h04, rd[4:0])
    `CHK("mode status", 4'h5, rd[9:6])
    readback_trigger_n_i = 1'b0;
    cyc(6);
    `CHK("tristate on", 1'b1, global_tristate_o)
    readback_trigger_n_i = 1'b1;
    cyc(6);
    `CHK("tristate off", 1'b0, global_tristate_o)
    $display("init and mode test done");
    // Slave serial byte, then own strobe in master and master parallel
    bus(1'b1, ccp_pkg::CTRL_ADDR, 32'h0);
    u_src.frame(8, 8'hb4);
    cyc(6);
    bus(1'b0, ccp_pkg::CFGDATA_ADDR, 32'h0);
    `CHK("serial byte", 32'h0000_00b4, rd)
    `CHK("slave strobe oe", 1'b0, config_strobe_clock_oe_o)
    bus(1'b1, ccp_pkg::CTRL_ADDR, 32'h20);
    cyc(4);
    `CHK("master strobe oe", 1'b1, config_strobe_clock_oe_o)
    `CHK("master no mem", 1'b0, mem_read_strobe_o)
    k = 0;
    p = config_strobe_clock_o;
    repeat (32) begin
      cyc(1);
      if (config_strobe_clock_o && !p) k++;
      p = config_strobe_clock_o;
    end
    `CHK("strobe rises", 4, k)
    bus(1'b1, ccp_pkg::CTRL_ADDR, 32'h60);
    k = 0;
    repeat (20) begin
      cyc(1);
      if (mem_read_strobe_o === 1'b1) k = 1;
    end
    `CHK("mem strobe", 1, k)
    $display("strobe test done");
    // Peripheral bytes: second one lands while busy and is dropped
    bus(1'b1, ccp_pkg::CTRL_ADDR, 32'h40);
    cyc(4);
    `CHK("ready idle", 1'b1, byte_ready_o)
    u_src.put_byte(8'h3c);
    u_src.put_byte(8'h99);
    #1;
    `CHK("busy", 1'b0, byte_ready_o)
    cyc(20);
    `CHK("ready again", 1'b1, byte_ready_o)
    bus(1'b0, ccp_pkg::CFGDATA_ADDR, 32'h0);
    `CHK("periph byte", 32'h0000_003c, rd)
    u_src.poll(1'b1);
    cyc(5);
    `CHK("status oe", 1'b1, status_bit_line_oe_o)
    `CHK("status ready", 1'b1, status_bit_line_o)
    u_src.poll(1'b0);
    cyc(5);
    `CHK("status off", 1'b0, status_bit_line_oe_o)
    bus(1'b1, ccp_pkg::CTRL_ADDR, 32'h50);
    cyc(4);
    `CHK("init fail", 1'b1, error_n_oe_o)
    $display("peripheral test done");
    // Load done with done held low, then start-up and interrupt
    bus(1'b1, ccp_pkg::CTRL_ADDR, 32'h0e);
    cyc(6);
    bus(1'b0, ccp_pkg::STATUS_ADDR, 32'h0);
    `CHK("state hold", 5'h08, rd[4:0])
    `CHK("done released", 1'b0, done_oe_o)
    `CHK("done pullup", 1'b1, done_pullup_o)
    `CHK("held off", 1'b0, startup_o)
    hold_done = 1'b0;
    cyc(6);
    `CHK("started", 1'b1, startup_o)
    `CHK("scan off", 1'b0, scan_enable_o)
    host_port_interrupt_n_i = 1'b0;
    cyc(3);
    `CHK("irq out", 1'b1, error_n_oe_o)
    host_port_interrupt_n_i = 1'b1;
    $display("start-up test done");
    // Readback from frame 0, first bit then one external shift
    bus(1'b1, ccp_pkg::RBDATA_ADDR, 32'h8000_00ff);
    readback_trigger_n_i = 1'b0;
    cyc(6);
    bus(1'b0, ccp_pkg::STATUS_ADDR, 32'h0);
    `CHK("rb active", 1'b1, rd[11])
    `CHK("rb frame", 16'h0, rd[27:12])
    bus(1'b0, ccp_pkg::RBDATA_ADDR, 32'h0);
    w = rd;
    `CHK("rb word", 32'h8000_00ff, w)
    `CHK("rb bit31", 1'b1, readback_data_o)
    u_src.frame(1, 8'h00);
    cyc(6);
    `CHK("rb bit30", 1'b0, readback_data_o)
    readback_trigger_n_i = 1'b1;
    $display("readback test done");
    // Restart in mid-run
    program_restart_n_i = 1'b0;
    cyc(8);
    `CHK("scan reset", 1'b1, scan_reset_o)
    `CHK("init low", 1'b1, init_oe_o)
    bus(1'b0, ccp_pkg::CTRL_ADDR, 32'h0);
    `CHK("load cleared", 1'b0, rd[1])
    program_restart_n_i = 1'b1;
    cyc(30);
    `CHK("scan reset off", 1'b0, scan_reset_o)
    bus(1'b0, ccp_pkg::STATUS_ADDR, 32'h0);
    `CHK("reload", 5'h04, rd[4:0])
    $display("restart test done");
    end_sim;
  end
endmodule
